// ==== acs_defs.svh ====
// constants of the converter configuration and channel-select block
// assumes a 100 MHz reference clock and a system clock made from it
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------------------------------
// register index carried on the two top data lines
// ----------------------------------------------------------------
`define ACS_IDX_PRIMARY 2'h0
`define ACS_IDX_SECONDARY 2'h1
`define ACS_PRIMARY_RESET 8'h00
`define ACS_SECONDARY_RESET 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACS_P_INTYPE 4
`define ACS_P_MODE_HI 3
`define ACS_P_MODE_LO 2
`define ACS_P_CHSEL_HI 1
`define ACS_P_CHSEL_LO 0
`define ACS_S_TRIG 6
`define ACS_S_RES_HI 5
`define ACS_S_RES_LO 4

// ----------------------------------------------------------------
// bus widths and conversion timing
// ----------------------------------------------------------------
`define ACS_BUS_W 10
`define ACS_REG_W 8
`define ACS_BITS_PER_STEP 2
`define ACS_CONV_STEPS 5
`define ACS_REF_PERIOD_NS 10
`define ACS_SYSTEM_CLOCK_PERIOD_NS 100
`define ACS_SYSTEM_CLOCK_DIV (`ACS_SYSTEM_CLOCK_PERIOD_NS / `ACS_REF_PERIOD_NS)

`endif

// ==== acs_pkg.sv ====
// types shared by the converter configuration block
// assumes acs_defs.svh sits in the include path
package acs_pkg;
  `include "acs_defs.svh"

  // one word of the parallel data bus: index on top, data below
  typedef logic [`ACS_BUS_W-1:0] acs_bus_t;

  // conversion mode field of the primary register
  typedef enum logic [1:0] {
    ACS_MONO_INT = 2'b00,
    ACS_DUAL_INT = 2'b01,
    ACS_MONO_CONT = 2'b10,
    ACS_DUAL_CONT = 2'b11
  } acs_mode_t;

  // sequencing of one or two conversions
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_CONV_A = 2'b01,
    ACS_CONV_B = 2'b10
  } acs_state_t;
endpackage

// ==== acs_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to clk
`timescale 1ns/1ps
module acs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // one stage pair per bit; meta is read only by q
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta[i] <= INIT[i];
        q[i] <= INIT[i];
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule // acs_sync

// ==== acs_conv_engine.sv ====
// recyclic conversion sequencer: two result bits per system clock
// assumes bit_pair is produced by the analog stage on the same clock
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_conv_engine #(
  parameter int DIV = `ACS_SYSTEM_CLOCK_DIV,
  parameter int STEPS = `ACS_CONV_STEPS,
  parameter int W = `ACS_BUS_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic start,
  input wire logic [1:0] bit_pair,
  output logic busy,
  output logic done,
  output logic [W-1:0] result
);
  import acs_pkg::*;
  localparam int LAT = DIV * STEPS;
  logic [$clog2(DIV+1)-1:0] pre;
  logic [$clog2(STEPS+1)-1:0] step;
  logic tick;
  logic [15:0] cyc;

  // system clock enable, restarted by each start so latency is exact
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pre <= '0;
    else if (clear || start || !busy || tick) pre <= '0;
    else pre <= pre + 1'b1;
  end
  assign tick = busy && (pre == ($bits(pre))'(DIV - 1));

  // step count: the word is complete after the fifth system clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      step <= '0;
      done <= 1'b0;
    end else begin
      done <= !clear && tick && (step == ($bits(step))'(STEPS - 1));
      if (clear) busy <= 1'b0;
      else if (start) begin
        busy <= 1'b1;
        step <= '0;
      end else if (tick) begin
        if (step == ($bits(step))'(STEPS - 1)) busy <= 1'b0;
        step <= step + 1'b1;
      end
    end
  end

  // serial pairs, most significant first, gathered into one word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) result <= '0;
    else if (start) result <= '0;
    else if (tick) result <= {result[W-3:0], bit_pair};
  end

  // cycle counter seen only by the latency check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cyc <= '0;
    else if (start) cyc <= 16'h0001;
    else if (busy) cyc <= cyc + 16'h0001;
  end

  a_conv_latency: assert property (@(posedge clk) disable iff (rst)
    done |-> cyc == 16'(LAT + 1))
    else $error("conversion did not take five system clocks");
  a_two_bits: assert property (@(posedge clk) disable iff (rst)
    (tick && !start) |=> result[1:0] == $past(bit_pair))
    else $error("result pair not taken on system clock");
endmodule // acs_conv_engine

// ==== acs_ctrl.sv ====
// configuration, channel select and bus logic of the converter
// assumes host strobes and pins are asynchronous to REF_CLK and that
// the analog stage feeds BIT_PAIR on REF_CLK
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_ctrl #(
  parameter int DIV = `ACS_SYSTEM_CLOCK_DIV
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic CONV_START_PIN_N,
  input wire logic PWRDN_REQ,
  input wire acs_pkg::acs_bus_t D_IN,
  input wire logic [1:0] BIT_PAIR,
  output acs_pkg::acs_bus_t D_OUT,
  output logic D_OE_N,
  output logic INT_OUT,
  output logic INT_OE_N,
  output logic [3:0] MUX_CH,
  output logic MUX_DIFF,
  output logic CONV_BUSY
);
  import acs_pkg::*;
  localparam int BW = `ACS_BUS_W;
  localparam int RW = `ACS_REG_W;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // analog switch pattern for a conversion; second picks the later one
  function automatic logic [3:0] chan_pick(input logic [RW-1:0] p,
                                           input logic second);
    logic [1:0] sel;
    logic diff;
    logic dual;
    sel = p[`ACS_P_CHSEL_HI:`ACS_P_CHSEL_LO];
    diff = p[`ACS_P_INTYPE];
    dual = p[`ACS_P_MODE_LO];
    if (!dual && !diff) chan_pick = 4'h1 << sel;
    else if (!dual) chan_pick = sel[1] ? 4'hC : 4'h3;
    else if (diff) chan_pick = second ? 4'hC : 4'h3;
    else if (!second) chan_pick = sel[0] ? 4'h2 : 4'h1;
    else chan_pick = sel[0] ? 4'h8 : 4'h4;
  endfunction

  // output word: polarity by input type, then width by resolution
  function automatic logic [BW-1:0] fmt(input logic [BW-1:0] r,
                                        input logic diff,
                                        input logic [1:0] res);
    logic [BW-1:0] v;
    v = diff ? {~r[BW-1], r[BW-2:0]} : r;
    unique case (res)
      2'b00: fmt = v;
      2'b10: fmt = {v[BW-1:2], 2'b00};
      default: fmt = {v[BW-1:6], 6'h00};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [4:0] strobe_s;
  logic [BW-1:0] d_s;
  logic cs_l, rd_l, wr_l, cst_l, pd_l;
  logic cs_d, rd_d, wr_d, cst_d;
  logic cs_fall, cs_rise, rd_fall, rd_rise, wr_rise, cst_rise;

  acs_sync #(.W(5), .INIT(5'h0F)) u_strobe_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({PWRDN_REQ, CONV_START_PIN_N, WR_N, RD_N, CS_N}),
    .q(strobe_s)
  );
  acs_sync #(.W(BW), .INIT('0)) u_data_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d(D_IN),
    .q(d_s)
  );
  assign {pd_l, cst_l, wr_l, rd_l, cs_l} = strobe_s;

  // previous levels for the edge detectors
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cs_d <= 1'b1;
      rd_d <= 1'b1;
      wr_d <= 1'b1;
      cst_d <= 1'b1;
    end else begin
      cs_d <= cs_l;
      rd_d <= rd_l;
      wr_d <= wr_l;
      cst_d <= cst_l;
    end
  end
  assign cs_fall = cs_d && !cs_l;
  assign cs_rise = !cs_d && cs_l;
  assign rd_fall = rd_d && !rd_l && !cs_l;
  assign rd_rise = !rd_d && rd_l && !cs_l;
  assign wr_rise = !wr_d && wr_l && !cs_l;
  assign cst_rise = !cst_d && cst_l; // start pin works without select

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [RW-1:0] primary_config;
  logic [RW-1:0] secondary_config;
  acs_mode_t mode;
  logic in_diff, trig_pin;
  logic [1:0] res_code;

  // stored on the write strobe rise; indexes 2 and 3 go nowhere
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      primary_config <= `ACS_PRIMARY_RESET;
      secondary_config <= `ACS_SECONDARY_RESET;
    end else if (wr_rise) begin
      if (d_s[BW-1:BW-2] == `ACS_IDX_PRIMARY)
        primary_config <= d_s[RW-1:0];
      else if (d_s[BW-1:BW-2] == `ACS_IDX_SECONDARY)
        secondary_config <= d_s[RW-1:0];
    end
  end

  assign mode = acs_mode_t'(primary_config[`ACS_P_MODE_HI:
                                           `ACS_P_MODE_LO]);
  assign in_diff = primary_config[`ACS_P_INTYPE];
  assign trig_pin = secondary_config[`ACS_S_TRIG];
  assign res_code = secondary_config[`ACS_S_RES_HI:`ACS_S_RES_LO];

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  logic is_int, is_dual, trig, start;
  acs_state_t state;
  logic eng_busy, eng_done;
  logic [BW-1:0] eng_result;

  assign is_int = (mode == ACS_MONO_INT) || (mode == ACS_DUAL_INT);
  assign is_dual = (mode == ACS_DUAL_INT) || (mode == ACS_DUAL_CONT);
  // interrupt modes follow the trigger bit; continuous use the read
  always_comb begin
    if (pd_l) trig = 1'b0;
    else if (is_int && trig_pin) trig = cst_rise;
    else trig = rd_fall;
  end
  assign start = (trig && state == ACS_IDLE && !cs_fall) ||
                 (state == ACS_CONV_A && eng_done && is_dual);

  acs_conv_engine #(.DIV(DIV), .STEPS(`ACS_CONV_STEPS), .W(BW)) u_eng (
    .clk(REF_CLK),
    .rst(RST),
    .clear(cs_fall),
    .start(start),
    .bit_pair(BIT_PAIR),
    .busy(eng_busy),
    .done(eng_done),
    .result(eng_result)
  );

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  // select fall aborts a conversion in flight, so no stale word lands
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) state <= ACS_IDLE;
    else if (cs_fall) state <= ACS_IDLE;
    else begin
      unique case (state)
        ACS_IDLE: if (trig) state <= ACS_CONV_A;
        ACS_CONV_A: if (eng_done) state <= is_dual ? ACS_CONV_B : ACS_IDLE;
        ACS_CONV_B: if (eng_done) state <= ACS_IDLE;
        default: state <= ACS_IDLE;
      endcase
    end
  end

  // results, formatted at capture; the second word of a dual pair
  logic [BW-1:0] word_a, word_b;
  logic rd_second;
  logic [BW-1:0] fmt_now;
  assign fmt_now = fmt(eng_result, in_diff, res_code);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      word_a <= '0;
      word_b <= '0;
    end else if (eng_done && state == ACS_CONV_A) word_a <= fmt_now;
    else if (eng_done && state == ACS_CONV_B) word_b <= fmt_now;
  end

  // which of the two dual words the next read returns
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) rd_second <= 1'b0;
    else if (cs_fall) rd_second <= 1'b0;
    else if (eng_done && state == ACS_CONV_B) rd_second <= 1'b0;
    else if (rd_rise && is_dual && !pd_l) rd_second <= !rd_second;
  end

  // ----------------------------------------------------------------
  // register readback in software power-down
  // ----------------------------------------------------------------
  logic [1:0] rb_ptr;
  logic [BW-1:0] rb_word;

  // pointer restarts on every power-down entry; after two reads it
  // rests, so extra reads keep showing the secondary register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) rb_ptr <= 2'h0;
    else if (!pd_l || cs_fall) rb_ptr <= 2'h0;
    else if (rd_rise && rb_ptr != 2'h2) rb_ptr <= rb_ptr + 2'h1;
  end
  always_comb begin
    if (rb_ptr == 2'h0) rb_word = {`ACS_IDX_PRIMARY, primary_config};
    else rb_word = {`ACS_IDX_SECONDARY, secondary_config};
  end

  // ----------------------------------------------------------------
  // data bus
  // ----------------------------------------------------------------
  logic drive;
  assign drive = !cs_l && !rd_l;

  // the bus only ever drives during a selected read, never on write
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      D_OE_N <= 1'b1;
      D_OUT <= '0;
    end else begin
      D_OE_N <= !drive;
      if (pd_l) D_OUT <= rb_word;
      else D_OUT <= rd_second ? word_b : word_a;
    end
  end

  // ----------------------------------------------------------------
  // end-of-conversion interrupt, open drain
  // ----------------------------------------------------------------
  logic int_set;
  assign int_set = eng_done && is_int &&
                   (state == ACS_CONV_B || !is_dual);
  // a set in the same cycle as a release keeps the line low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) INT_OE_N <= 1'b1;
    else if (int_set) INT_OE_N <= 1'b0;
    else if (cs_rise || rd_rise || cs_fall) INT_OE_N <= 1'b1;
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) INT_OUT <= 1'b0;
    else INT_OUT <= 1'b0;
  end

  // ----------------------------------------------------------------
  // analog switch and busy outputs
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      MUX_CH <= 4'h0;
      MUX_DIFF <= 1'b0;
      CONV_BUSY <= 1'b0;
    end else begin
      MUX_CH <= chan_pick(primary_config, state == ACS_CONV_B);
      MUX_DIFF <= in_diff;
      CONV_BUSY <= eng_busy;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pd_no_start: assert property (@(posedge REF_CLK) disable iff (RST)
    (pd_l && state == ACS_IDLE) |=> state == ACS_IDLE)
    else $error("conversion started in power-down");
  a_bus_enable: assert property (@(posedge REF_CLK) disable iff (RST)
    !D_OE_N |-> $past(!cs_l && !rd_l))
    else $error("bus driven outside a selected read");
  a_write_primary: assert property (@(posedge REF_CLK) disable iff (RST)
    (wr_rise && d_s[BW-1:BW-2] == 2'h0) |=>
      primary_config == $past(d_s[RW-1:0]))
    else $error("primary register not written");
  a_int_release: assert property (@(posedge REF_CLK) disable iff (RST)
    (rd_rise && !int_set) |=> INT_OE_N)
    else $error("interrupt not released by read rise");
  a_int_set: assert property (@(posedge REF_CLK) disable iff (RST)
    int_set |=> !INT_OE_N)
    else $error("interrupt not driven at end of conversion");
  a_cs_clears: assert property (@(posedge REF_CLK) disable iff (RST)
    cs_fall |=> state == ACS_IDLE && !rd_second && rb_ptr == 2'h0)
    else $error("select fall did not reset control");
  a_readback_ord: assert property (@(posedge REF_CLK) disable iff (RST)
    (pd_l && $past(pd_l) && rb_ptr == 2'h1) |=>
      D_OUT == {`ACS_IDX_SECONDARY, $past(secondary_config)})
    else $error("readback order wrong");
  a_dual_se_pair: assert property (@(posedge REF_CLK) disable iff (RST)
    (is_dual && !in_diff && state == ACS_CONV_B && !primary_config[0])
      |=> MUX_CH == 4'h4)
    else $error("dual single-ended pair wrong");
endmodule // acs_ctrl

// ==== acs_analog_model.sv ====
// analog stage and board pull-up model facing the configuration block
// assumes the block samples bit_pair only while it reports busy
`timescale 1ns/1ps
module acs_analog_model #(
  parameter logic [1:0] PAT = 2'b10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_busy,
  input wire logic int_out,
  input wire logic int_oe_n,
  output logic [1:0] bit_pair,
  output logic int_line
);
  // ------------------------------------------------------------
  // result bits
  // ------------------------------------------------------------
  // outside a conversion the pair flips so a stray sample shows up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_pair <= ~PAT;
    end else begin
      bit_pair <= conv_busy ? PAT : ~PAT;
    end
  end

  // open-drain interrupt line with its pull-up
  assign int_line = int_oe_n ? 1'b1 : int_out;
endmodule // acs_analog_model

// ==== acs_ctrl_tb.sv ====
// self-checking bench for the converter configuration block
// assumes acs_pkg and the design files are compiled first
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_ctrl_tb;
  import acs_pkg::*;
  localparam int DIV = 4; // short system clock keeps the run brief
  localparam logic [1:0] PAT = 2'b10;
  logic clk, rst, cs_n, rd_n, wr_n, start_n, pwrdn;
  logic [`ACS_BUS_W-1:0] d_in, d_out;
  logic [1:0] bit_pair;
  logic d_oe_n, int_out, int_oe_n, mux_diff, conv_busy, int_line;
  logic [3:0] mux_ch;
  int mismatches, tests_run, cycles, n;

  acs_ctrl #(.DIV(DIV)) dut (.REF_CLK(clk), .RST(rst), .CS_N(cs_n),
    .RD_N(rd_n), .WR_N(wr_n), .CONV_START_PIN_N(start_n),
    .PWRDN_REQ(pwrdn), .D_IN(d_in), .BIT_PAIR(bit_pair), .D_OUT(d_out),
    .D_OE_N(d_oe_n), .INT_OUT(int_out), .INT_OE_N(int_oe_n),
    .MUX_CH(mux_ch), .MUX_DIFF(mux_diff), .CONV_BUSY(conv_busy));
  acs_analog_model #(.PAT(PAT)) far (.clk(clk), .rst(rst),
    .conv_busy(conv_busy), .int_out(int_out), .int_oe_n(int_oe_n),
    .bit_pair(bit_pair), .int_line(int_line));

  // ------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ceiling is about fifteen times the expected length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // data held four cycles before the write strobe rises
  task automatic write_reg(input logic [1:0] idx, input logic [7:0] v);
    cs_n = 1'b0;
    step(1);
    d_in = {idx, v};
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(4);
    cs_n = 1'b1;
    d_in = ~d_in;
    step(4);
  endtask
  task automatic readback(input logic [7:0] p, input logic [7:0] s);
    pwrdn = 1'b1;
    step(4);
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(5);
    check("bus enable", {9'h0, d_oe_n}, 10'h000);
    check("readback first", d_out, {2'b00, p});
    rd_n = 1'b1;
    step(5);
    check("bus released", {9'h0, d_oe_n}, 10'h001);
    rd_n = 1'b0;
    step(5);
    check("readback second", d_out, {2'b01, s});
    check("no pd conversion", {9'h0, conv_busy}, 10'h000);
    rd_n = 1'b1;
    cs_n = 1'b1;
    pwrdn = 1'b0;
    step(4);
  endtask
  function automatic logic [9:0] word(input logic diff,
                                      input logic [1:0] res);
    logic [9:0] w;
    w = {5{PAT}};
    w[9] = w[9] ^ diff;
    if (res == 2'b10) w = w & 10'h3FC;
    else if (res != 2'b00) w = w & 10'h3C0;
    return w;
  endfunction
  function automatic logic [3:0] mux_exp(input logic diff,
    input logic [1:0] mode, input logic [1:0] sel);
    if (!mode[0]) return diff ? (sel[1] ? 4'hC : 4'h3) : 4'h1 << sel;
    // dual modes: between conversions the switch shows the first one
    return diff ? 4'h3 : (sel[0] ? 4'h2 : 4'h1);
  endfunction
  task automatic wait_busy();
    n = 0;
    while (conv_busy !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    check("busy seen", {9'h0, conv_busy}, 10'h001);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, cs_n, rd_n, wr_n, start_n} = 5'h1F;
    pwrdn = 1'b0;
    d_in = 10'h000;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    step(10);
    rst = 1'b0;
    step(2);
    check("int idle", {9'h0, int_line}, 10'h001);
    readback(8'h00, 8'h00);
    // all eight bits stored, unused index refused
    write_reg(2'h0, 8'hA5);
    write_reg(2'h1, 8'h5A);
    write_reg(2'h2, 8'hFF);
    write_reg(2'h3, 8'h00);
    readback(8'hA5, 8'h5A);
    // channel switch over every type, mode and select code
    for (int i = 0; i < 32; i++) begin
      write_reg(2'h0, i[7:0]);
      check("mux", {6'h0, mux_ch}, {6'h0, mux_exp(i[4], i[3:2],
        i[1:0])});
      check("diff", {9'h0, mux_diff}, {9'h0, i[4]});
    end
    // read strobe trigger, every resolution, both input types
    for (int i = 0; i < 8; i++) begin
      write_reg(2'h0, {3'h0, i[2], 4'h0});
      write_reg(2'h1, {2'h0, i[1:0], 4'h0});
      cs_n = 1'b0;
      step(2);
      rd_n = 1'b0;
      wait_busy();
      n = 0;
      while (int_line !== 1'b0 && n < 200) begin
        step(1);
        n++;
      end
      check("conv cycles", n[9:0], 10'(5 * DIV));
      step(2);
      check("result", d_out, word(i[2], i[1:0]));
      rd_n = 1'b1;
      step(5);
      check("int release", {9'h0, int_line}, 10'h001);
      cs_n = 1'b1;
      step(4);
    end
    // start pin trigger, dual differential, two words
    write_reg(2'h1, 8'h40);
    write_reg(2'h0, 8'h14);
    start_n = 1'b0;
    step(3);
    start_n = 1'b1;
    wait_busy();
    n = 0;
    while (int_line !== 1'b0 && n < 300) begin
      step(1);
      n++;
    end
    check("dual int", {9'h0, int_line}, 10'h000);
    cs_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      rd_n = 1'b0;
      step(5);
      check("dual word", d_out, word(1'b1, 2'b00));
      rd_n = 1'b1;
      step(5);
    end
    check("dual release", {9'h0, int_line}, 10'h001);
    cs_n = 1'b1;
    step(4);
    // continuous modes never raise the interrupt; dual shows CH2 second
    write_reg(2'h1, 8'h00);
    for (int m = 0; m < 2; m++) begin
      write_reg(2'h0, m ? 8'h0C : 8'h08);
      cs_n = 1'b0;
      step(2);
      rd_n = 1'b0;
      wait_busy();
      step(5 * DIV + 10);
      check("cont no int", {9'h0, int_line}, 10'h001);
      check("cont mux", {6'h0, mux_ch}, m ? 10'h004 : 10'h001);
      rd_n = 1'b1;
      cs_n = 1'b1;
      step(4);
    end
    // chip select fall aborts a running conversion
    write_reg(2'h0, 8'h00);
    cs_n = 1'b0;
    step(2);
    rd_n = 1'b0;
    wait_busy();
    rd_n = 1'b1;
    cs_n = 1'b1;
    step(4);
    cs_n = 1'b0;
    step(5);
    check("abort busy", {9'h0, conv_busy}, 10'h000);
    step(5 * DIV + 5);
    check("abort int", {9'h0, int_line}, 10'h001);
    cs_n = 1'b1;
    step(4);
    conclude();
  end
endmodule // acs_ctrl_tb
